// [inc/sld_pkg.sv]
// shared constants for the serial shift-and-latch drive block
// assumes one system clock; every device pin arrives asynchronously
package sld_pkg;
	localparam int STAGES      = 8;
	localparam int BUF_DEPTH   = 2;
	localparam int BUF_WIDTH   = 1;
	localparam int SYNC_STAGES = 2;
	localparam logic RST_BIT   = 1'h0;
	localparam logic [STAGES-1:0] RST_BYTE = 8'h00;
	localparam logic [STAGES-1:0] RST_OFF  = 8'h00;
	localparam logic [STAGES-1:0] DRIVE_LEVEL = 8'h00;
	localparam int CLK_PERIOD_NS = 40;
endpackage

// [src/sld_fifo.sv]
// small valid/ready buffer holding sampled serial bits
// assumes a single clock; writer and reader share it
`timescale 1ns/10ps
`default_nettype none
module sld_fifo
	import sld_pkg::*;
#(
	parameter int WIDTH = BUF_WIDTH,
	parameter int DEPTH = BUF_DEPTH
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// fill side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// drain side
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wrPtr;
		logic [PW-1:0]               rdPtr;
		logic [PW:0]                 count;
	} sld_fifo_t;

	sld_fifo_t st_ff;
	sld_fifo_t nxt_st;
	logic      doWrite;
	logic      doRead;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
	endfunction

	assign inReady  = (st_ff.count != FULL_CNT);
	assign outValid = (st_ff.count != '0);
	assign outData  = st_ff.mem[st_ff.rdPtr];
	assign doWrite  = inValid & inReady;
	assign doRead   = outValid & outReady;

	always_comb begin
		nxt_st = st_ff;
		if (doWrite) begin
			nxt_st.mem[st_ff.wrPtr] = inData;
			nxt_st.wrPtr = bump(st_ff.wrPtr);
		end
		if (doRead) begin
			nxt_st.rdPtr = bump(st_ff.rdPtr);
		end
		case ({doWrite, doRead})
			2'b10: nxt_st.count = st_ff.count + 1'b1;
			2'b01: nxt_st.count = st_ff.count - 1'b1;
			default: nxt_st.count = st_ff.count;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule
`default_nettype wire

// [src/sld_driver.sv]
// serial shift chain with storage latches and open-drain drive lines
// assumes shift clock, data, strobe and enable are asynchronous pins
//
// Behaviour
// R1 - eight shift stages, each with own latch
// R2 - rising shift clock samples data, advances chain
// R3 - latches follow stages while transfer high
// R4 - enable low releases every drive line
// R5 - drive lines only pull low or release
// R6 - rising edge moves stage seven to eight, cascade
// R7 - falling cascade output takes stage eight later
// R8 - fast downstream devices use rising cascade
// R9 - host shifts eight bits, then pulses transfer
`timescale 1ns/10ps
`default_nettype none
module sld_driver
	import sld_pkg::*;
#(
	parameter int N = STAGES
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// serial side pins
	input  wire logic         shiftClock,
	input  wire logic         serialData,
	input  wire logic         latchTransfer,
	input  wire logic         outputDriveEnable,
	// cascade outputs
	output logic              riseCascade,
	output logic              fallCascade,
	// open-drain parallel drive lines
	input  wire logic [N-1:0] lineIn,
	output logic [N-1:0]      lineOut,
	output logic [N-1:0]      lineOe,
	// buffer status
	output logic              bitReady
);
	typedef struct packed {
		logic [SYNC_STAGES:0]   clkSync;
		logic [SYNC_STAGES-1:0] dataSync;
		logic [SYNC_STAGES-1:0] strSync;
		logic [SYNC_STAGES-1:0] enSync;
		logic [N-1:0]           stage;
		logic [N-1:0]           latch;
		logic [N-1:0]           oe;
		logic [N-1:0]           out;
		logic                   riseOut;
		logic                   fallOut;
		logic                   fallPend;
		logic                   gap;
		logic                   ready;
	} sld_state_t;

	sld_state_t   st_ff;
	sld_state_t   nxt_st;

	// pin views after synchronising
	logic         riseEv;
	logic         fallEv;
	logic         strobeSeen;
	logic         enableSeen;

	// buffer handshake
	logic         bufValid;
	logic         bufData;
	logic         bufInReady;
	logic         popReady;
	logic         pop;
	logic         fallDue;

	// per-line next values
	logic [N-1:0] stageSrc;
	logic [N-1:0] shiftedStage;
	logic [N-1:0] followLatch;
	logic [N-1:0] pullEnable;
	logic [N-1:0] pinLevel;

	// true when the synchronised level moved the given way
	function automatic logic edgeSeen(
		input logic newer,
		input logic older,
		input logic toHigh
	);
		logic moved;
		moved = newer ^ older;
		if (toHigh) begin
			edgeSeen = moved & newer;
		end else begin
			edgeSeen = moved & older;
		end
	endfunction

	// a line pulls low for a stored zero, only while enabled
	function automatic logic pullLow(
		input logic stored,
		input logic enabled
	);
		if (enabled) begin
			pullLow = ~stored;
		end else begin
			pullLow = 1'b0;
		end
	endfunction

	// a cascade output takes a new bit only on its own event
	function automatic logic cascadeNext(
		input logic take,
		input logic fresh,
		input logic held
	);
		if (take) begin
			cascadeNext = fresh;
		end else begin
			cascadeNext = held;
		end
	endfunction

	// edges seen only after the second synchroniser flop
	assign riseEv     = edgeSeen(st_ff.clkSync[SYNC_STAGES-1], st_ff.clkSync[SYNC_STAGES], 1'b1);
	assign fallEv     = edgeSeen(st_ff.clkSync[SYNC_STAGES-1], st_ff.clkSync[SYNC_STAGES], 1'b0);

	assign strobeSeen = st_ff.strSync[SYNC_STAGES-1];
	assign enableSeen = st_ff.enSync[SYNC_STAGES-1];

	// one idle cycle after each pop lets the falling cascade catch up
	assign popReady   = ~st_ff.gap;
	assign pop        = bufValid & popReady;
	// a fall waits until every earlier rise has been applied
	assign fallDue    = (st_ff.fallPend | fallEv) & ~bufValid & ~pop;

	sld_fifo #(
		.WIDTH(BUF_WIDTH),
		.DEPTH(BUF_DEPTH)
	) u_fifo (
		.clk     (clk),
		.rst     (rst),
		.inValid (riseEv),
		.inData  (st_ff.dataSync[SYNC_STAGES-1]),
		.inReady (bufInReady),
		.outValid(bufValid),
		.outData (bufData),
		.outReady(popReady)
	);

	// lineIn is not read: an open-drain line needs no readback here
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_line
			// serial bit into stage zero, neighbour elsewhere
			if (g == 0) begin : gen_head
				assign stageSrc[g] = bufData;
			end else begin : gen_tail
				assign stageSrc[g] = st_ff.stage[g-1];
			end
			assign shiftedStage[g] = pop ? stageSrc[g] : st_ff.stage[g]; // R1 R2
			// latch is transparent, sampled on the system clock
			assign followLatch[g]  = strobeSeen ? shiftedStage[g] : st_ff.latch[g]; // R3
			// pin level fixed, only the enable moves
			assign pullEnable[g]   = pullLow(followLatch[g], enableSeen); // R4
			assign pinLevel[g]     = 1'b0; // R5
		end
	endgenerate

	always_comb begin
		nxt_st = st_ff;

		// a metastable first flop is never read by logic
		nxt_st.clkSync  = {st_ff.clkSync[SYNC_STAGES-1:0], shiftClock};
		nxt_st.dataSync = {st_ff.dataSync[SYNC_STAGES-2:0], serialData};
		nxt_st.strSync  = {st_ff.strSync[SYNC_STAGES-2:0], latchTransfer};
		nxt_st.enSync   = {st_ff.enSync[SYNC_STAGES-2:0], outputDriveEnable};

		nxt_st.gap   = pop;
		nxt_st.ready = bufInReady;

		// chain and rising cascade move together on a pop
		nxt_st.stage   = shiftedStage; // R1 R2
		nxt_st.riseOut = cascadeNext(pop, st_ff.stage[N-2], st_ff.riseOut); // R6 R8

		nxt_st.fallOut = cascadeNext(fallDue, st_ff.stage[N-1], st_ff.fallOut); // R7
		if (fallDue) begin
			nxt_st.fallPend = 1'b0;
		end else if (fallEv) begin
			nxt_st.fallPend = 1'b1;
		end else begin
			nxt_st.fallPend = st_ff.fallPend;
		end

		nxt_st.latch = followLatch; // R3
		nxt_st.out   = pinLevel; // R5
		nxt_st.oe    = pullEnable; // R4
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign riseCascade = st_ff.riseOut;
	assign fallCascade = st_ff.fallOut;
	assign lineOut     = st_ff.out;
	assign lineOe      = st_ff.oe;
	assign bitReady    = st_ff.ready;
endmodule
`default_nettype wire

// [tb/sld_driver_sva.sv]
// pin checks of the drive block
// bound into sld_driver, one clock
`timescale 1ns/10ps
`default_nettype none
module sld_driver_sva #(parameter int N = 8) (
	input wire logic clk, rst, shiftClock, latchTransfer, outputDriveEnable,
	input wire logic riseCascade, fallCascade,
	input wire logic [N-1:0] lineOut, lineOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_od; ~|lineOut; endproperty
	a_od: assert property (p_od) else $error("drive high");
	property p_off; !outputDriveEnable[*4] |-> ~|lineOe; endproperty
	a_off: assert property (p_off) else $error("not off");
	property p_hold; (!latchTransfer && outputDriveEnable)[*8] |-> $stable(lineOe); endproperty
	a_hold: assert property (p_hold) else $error("latch moved");
	property p_rq; !shiftClock[*8] |-> $stable(riseCascade); endproperty
	a_rq: assert property (p_rq) else $error("rise moved");
	property p_fq; !shiftClock[*8] |-> $stable(fallCascade); endproperty
	a_fq: assert property (p_fq) else $error("fall moved");
	property p_rt; $changed(riseCascade) |-> $past(shiftClock, 4); endproperty
	a_rt: assert property (p_rt) else $error("rise late");
	property p_ft; $changed(fallCascade) |-> !$past(shiftClock, 3); endproperty
	a_ft: assert property (p_ft) else $error("fall early");
	property p_pr; $changed(fallCascade) |-> fallCascade == riseCascade; endproperty
	a_pr: assert property (p_pr) else $error("fall differs");
endmodule
bind sld_driver sld_driver_sva #(.N(N)) i_sva (.*);
`default_nettype wire

// [tb/sld_host.sv]
// host model: one byte msb first per go
// serial clock idles low between bytes
`timescale 1ns/10ps
`default_nettype none
module sld_host (
	input wire logic clk, go,
	input wire logic [7:0] dat,
	output logic shiftClock = 1'h0, serialData = 1'h0, busy = 1'h0
);
	logic [5:0] cnt = 6'h0;
	always @(posedge clk) begin
		if (go)
			busy <= 1'h1;
		if (busy) begin
			cnt <= cnt + 6'h1;
			// data leads the rise by 3, slow enough for the buffer
			shiftClock <= cnt[2:0] - 3'h3 < 3'h4;
			serialData <= &cnt ? ~serialData : dat[~cnt[5:3]];
			busy <= ~&cnt;
		end
	end
endmodule
`default_nettype wire

// [tb/serial_shift_latch_led_driver_bench.sv]
// bytes 5a and ff, then random ones, through the host model
// assumes 40 ns clk, rst high 20 cycles
`timescale 1ns/10ps
`default_nettype none
module serial_shift_latch_led_driver_bench;
	logic clk = 1'h0, rst = 1'h1, go = 1'h0, latchTransfer = 1'h0, outputDriveEnable = 1'h1;
	logic [7:0] dat = 8'h0, held = 8'h0, b;
	wire shiftClock, serialData, busy, riseCascade, fallCascade, bitReady;
	wire [7:0] lineOut, lineOe, lineIn = ~lineOe | lineOut;
	int error_cnt = 0, samples_checked = 0, seed = 81, cyc = 0, i, n;
	sld_host i_host (.*);
	sld_driver i_dut (.*);
	initial forever #20 clk = ~clk;
	always @(posedge clk) if (++cyc > 2500) begin
		error_cnt++;
		test_done;
	end
	function automatic logic [7:0] lines(input logic [7:0] l, input logic e);
		return e ? ~l : 8'h0;
	endfunction
	task chk(input logic [7:0] e, g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask
	task test_done;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task wt(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	initial begin
		wt(20);
		rst = 1'h0;
		for (n = 0; n < 10; n++) begin
			b = n == 0 ? 8'h5a : n == 1 ? 8'hff : 8'($random(seed));
			dat = b;
			go = 1'h1;
			wt(1);
			go = 1'h0;
			for (i = 0; i < 99 && busy === 1'h1; i++) wt(1);
			wt(10);
			chk(8'h01, 8'(bitReady));
			chk(8'(b[7]), 8'(riseCascade));
			chk(8'(b[7]), 8'(fallCascade));
			chk(lines(held, outputDriveEnable), lineOe);
			latchTransfer = 1'h1;
			wt(6);
			latchTransfer = 1'h0;
			wt(6);
			held = b;
			chk(lines(b, outputDriveEnable), lineOe);
			outputDriveEnable = n[0];
		end
		test_done;
	end
endmodule
`default_nettype wire
